// ==== hdl/nv_backed_sram_control.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Read: select and output enable low, write enable and busy high.
// [R2] Read data follows address; held here until the access completes.
// [R3] Write: select and write enable low, busy high; data held to the end.
// [R4] Host holds address stable through writes and keeps output enable high.
// [R5] Device turns its drivers off if output enable low in a write.
// [R6] Saves start by busy pin, software sequence or power failure.
// [R7] Power-fail save runs from the reservoir when enabled.
// [R8] Automatic and pin saves skipped unless written since last transfer.
// [R9] Software save always runs.
// [R10] Pulling busy low starts a conditional save after a wait.
// [R11] Device holds busy low for every save; host waits for release.
// [R12] Writes after busy falls are blocked until it rises.
// [R13] Host must release busy; no access while busy is low.
// [R14] Device stays disabled until busy returns high.
// [R15] Restore at power-up runs with busy held low.
// [R16] Software save: six reads, write enable high, exact address order.
// [R17] Any other access between sequence reads aborts it.
// [R18] Save erases then programs; host issues nothing meanwhile.
// [R19] Restore sequence ends with its own address; reads clocked by select.
// [R20] Restore clears then copies; host waits for busy release.
// [R21] Power-fail save disable and enable sequences; read data returned.
// [R22] Only low 14 address bits matter for sequence recognition.
// [R23] Select high between accesses leaves the device idle.
// [R24] Output enable high except while the host samples a read.
// [R25] Device delays are parameters; host waits on the busy pin.
module nv_backed_sram_control
  import nv_host_pkg::*;
#(
  parameter int OP_CYCLES = OP_CYC,
  parameter int REQ_HOLD  = STORE_WAIT_CYC
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  // Host request port
  input  wire logic              req_valid_i,
  input  wire req_s              req_i,
  output logic                   req_ready_o,
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_rdata_o,
  // Device control and address pins
  output logic                   chip_select_n_o,
  output logic                   output_enable_n_o,
  output logic                   write_enable_n_o,
  output logic [ADDR_W-1:0]      address_bus_o,
  // Data bus, three signals
  input  wire logic [DATA_W-1:0] data_bus_i,
  output logic [DATA_W-1:0]      data_bus_o,
  output logic                   data_bus_oe_o,
  // Open-drain busy pin, three signals
  input  wire logic              store_busy_n_i,
  output logic                   store_busy_n_o,
  output logic                   store_busy_n_oe_o
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ACCESS,
    ST_GAP,
    ST_HWREQ,
    ST_WAIT_BUSY
  } state_e;

  logic                 rst_a_ff;
  logic                 rst_n_ff;
  logic [DATA_W:0]      pin_sync;
  logic [DATA_W-1:0]    din_sync;
  logic                 busy_sync;

  state_e               state_ff, nxt_state;
  pins_s                pins_ff, nxt_pins;
  logic [DATA_W-1:0]    dout_ff, nxt_dout;
  logic                 doe_ff, nxt_doe;
  logic                 bdrv_ff, nxt_bdrv;
  logic                 ready_ff, nxt_ready;
  logic                 rvalid_ff, nxt_rvalid;
  logic [DATA_W-1:0]    rdata_ff, nxt_rdata;
  req_s                 cur_ff, nxt_cur;
  logic [2:0]           step_ff, nxt_step;
  logic [15:0]          cnt_ff, nxt_cnt;

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_a_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_n_ff <= rst_a_ff;
    end
  end

  // Data and busy pins come from outside the clock domain
  nv_pin_sync #(.W(DATA_W + 1)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_ff),
    .async_i ({store_busy_n_i, data_bus_i}),
    .sync_o  (pin_sync)
  );
  assign busy_sync = pin_sync[DATA_W];
  assign din_sync  = pin_sync[DATA_W-1:0];

  // Address of step n of a software sequence
  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] n, input cmd_e c);
    logic [ADDR_W-1:0] a;
    a = SEQ_A1;
    case (n)
      3'h0: a = SEQ_A1;
      3'h1: a = SEQ_A2;
      3'h2: a = SEQ_A3;
      3'h3: a = SEQ_A4;
      3'h4: a = SEQ_A5;
      default: begin
        case (c)
          CMD_SW_SAVE:    a = SEQ_SAVE;
          CMD_SW_RESTORE: a = SEQ_RESTORE;
          CMD_PF_OFF:     a = SEQ_PF_OFF;
          default:        a = SEQ_PF_ON;
        endcase
      end
    endcase
    // Top bit is ignored by the device; drive it low
    return {1'b0, a[SEQ_ADDR_W-1:0]}; // see [R22]
  endfunction : seq_addr

  function automatic logic is_seq(input cmd_e c);
    return (c == CMD_SW_SAVE) || (c == CMD_SW_RESTORE) ||
           (c == CMD_PF_OFF) || (c == CMD_PF_ON);
  endfunction : is_seq

  // Sequencer next state
  always_comb begin
    nxt_state  = state_ff;
    nxt_pins   = pins_ff;
    nxt_dout   = dout_ff;
    nxt_doe    = doe_ff;
    nxt_bdrv   = bdrv_ff;
    nxt_ready  = 1'b0;
    nxt_rvalid = 1'b0;
    nxt_rdata  = rdata_ff;
    nxt_cur    = cur_ff;
    nxt_step   = step_ff;
    nxt_cnt    = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        // Accept only while busy is high; device is disabled otherwise
        if (ready_ff && req_valid_i) begin // see [R13] [R14]
          nxt_cur  = req_i;
          nxt_step = 3'h0;
          nxt_cnt  = 16'h0000;
          if (req_i.cmd == CMD_HW_SAVE) begin
            nxt_bdrv  = 1'b1; // see [R6] [R10]
            nxt_state = ST_HWREQ;
          end else begin
            nxt_pins.address_bus = is_seq(req_i.cmd) ? seq_addr(3'h0, req_i.cmd) : req_i.addr;
            nxt_state = ST_SETUP; // see [R4]
          end
        end else begin
          nxt_ready = busy_sync && !ready_ff && !rvalid_ff;
        end
      end
      ST_SETUP: begin
        // Address already stable; now assert the strobes
        nxt_pins.chip_select_n = 1'b0;
        if (cur_ff.cmd == CMD_WRITE) begin
          nxt_pins.write_enable_n  = 1'b0; // see [R3]
          nxt_pins.output_enable_n = 1'b1; // see [R4] [R5]
          nxt_dout = cur_ff.wdata;
          nxt_doe  = 1'b1;
        end else begin
          nxt_pins.write_enable_n  = 1'b1; // see [R1] [R16]
          nxt_pins.output_enable_n = 1'b0; // see [R24]
        end
        nxt_cnt   = 16'h0000;
        nxt_state = ST_ACCESS;
      end
      ST_ACCESS: begin
        nxt_cnt = cnt_ff + 16'h0001;
        // Synchroniser adds two cycles before read data is seen
        if (cnt_ff >= 16'(OP_CYCLES + 2)) begin // see [R2]
          nxt_rdata = din_sync;
          nxt_pins.chip_select_n   = 1'b1; // see [R19] [R23]
          nxt_pins.output_enable_n = 1'b1;
          nxt_pins.write_enable_n  = 1'b1; // see [R3]
          nxt_state = ST_GAP;
        end
      end
      ST_GAP: begin
        // Data released one cycle after strobes so the write latches it
        nxt_doe = 1'b0;
        if (is_seq(cur_ff.cmd) && step_ff != 3'h5) begin
          // Back-to-back sequence reads, nothing in between
          nxt_step = step_ff + 3'h1; // see [R17]
          nxt_pins.address_bus = seq_addr(step_ff + 3'h1, cur_ff.cmd);
          nxt_state = ST_SETUP;
        end else begin
          nxt_rvalid = (cur_ff.cmd == CMD_READ) || (cur_ff.cmd == CMD_PF_OFF) ||
                       (cur_ff.cmd == CMD_PF_ON); // see [R21]
          nxt_cnt   = 16'h0000;
          nxt_state = ST_WAIT_BUSY; // see [R9] [R18] [R20]
        end
      end
      ST_HWREQ: begin
        // Hold the request long enough for the device to see it
        nxt_cnt = cnt_ff + 16'h0001;
        if (cnt_ff >= 16'(REQ_HOLD + 2)) begin
          nxt_bdrv  = 1'b0;
          nxt_cnt   = 16'h0000;
          nxt_state = ST_WAIT_BUSY; // see [R8] [R11]
        end
      end
      ST_WAIT_BUSY: begin
        // Let the device pull busy before trusting a high level
        nxt_cnt = (cnt_ff == 16'hFFFF) ? cnt_ff : cnt_ff + 16'h0001;
        if (cnt_ff >= 16'(REQ_HOLD + 4) && busy_sync) begin // see [R7] [R15] [R25]
          nxt_ready = 1'b1; // see [R12]
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff  <= ST_WAIT_BUSY; // Pin level unknown until the synchroniser fills
      pins_ff   <= '{chip_select_n: 1'b1, output_enable_n: 1'b1,
                     write_enable_n: 1'b1, address_bus: '0};
      dout_ff   <= 8'h00;
      doe_ff    <= 1'b0;
      bdrv_ff   <= 1'b0;
      ready_ff  <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff  <= 8'h00;
      cur_ff    <= '0;
      step_ff   <= 3'h0;
      cnt_ff    <= 16'h0000;
    end else begin
      state_ff  <= nxt_state;
      pins_ff   <= nxt_pins;
      dout_ff   <= nxt_dout;
      doe_ff    <= nxt_doe;
      bdrv_ff   <= nxt_bdrv;
      ready_ff  <= nxt_ready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      cur_ff    <= nxt_cur;
      step_ff   <= nxt_step;
      cnt_ff    <= nxt_cnt;
    end
  end

  // All outputs straight from flops, except store_busy_n_o, which is tied low
  assign req_ready_o       = ready_ff;
  assign rsp_valid_o       = rvalid_ff;
  assign rsp_rdata_o       = rdata_ff;
  assign chip_select_n_o   = pins_ff.chip_select_n;
  assign output_enable_n_o = pins_ff.output_enable_n;
  assign write_enable_n_o  = pins_ff.write_enable_n;
  assign address_bus_o     = pins_ff.address_bus;
  assign data_bus_o        = dout_ff;
  assign data_bus_oe_o     = doe_ff;
  assign store_busy_n_o    = 1'b0;
  assign store_busy_n_oe_o = bdrv_ff;

endmodule : nv_backed_sram_control

// ==== hdl/nv_host_pkg.sv ====
package nv_host_pkg;

  // Array and bus widths
  localparam int ADDR_W     = 15;
  localparam int DATA_W     = 8;
  localparam int SEQ_ADDR_W = 14;

  // Software sequence addresses, low 14 bits compared
  localparam logic [14:0] SEQ_A1      = 15'h0E38;
  localparam logic [14:0] SEQ_A2      = 15'h31C7;
  localparam logic [14:0] SEQ_A3      = 15'h03E0;
  localparam logic [14:0] SEQ_A4      = 15'h3C1F;
  localparam logic [14:0] SEQ_A5      = 15'h303F;
  localparam logic [14:0] SEQ_SAVE    = 15'h0FC0;
  localparam logic [14:0] SEQ_RESTORE = 15'h0C63;
  localparam logic [14:0] SEQ_PF_OFF  = 15'h0B45;
  localparam logic [14:0] SEQ_PF_ON   = 15'h0B46;

  // Pin timing in ns, converted to cycles at 10 MHz
  localparam int CLK_NS          = 100;
  localparam int ACCESS_NS       = 45;
  localparam int SETUP_NS        = 30;
  localparam int ACCESS_CYC      = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC       = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int OP_CYC          = (ACCESS_CYC > SETUP_CYC) ? ACCESS_CYC : SETUP_CYC;
  localparam int STORE_WAIT_CYC  = 2;
  localparam int RESET_FF_VAL    = 0;

  // Host commands
  typedef enum logic [2:0] {
    CMD_READ,
    CMD_WRITE,
    CMD_SW_SAVE,
    CMD_SW_RESTORE,
    CMD_PF_OFF,
    CMD_PF_ON,
    CMD_HW_SAVE
  } cmd_e;

  typedef struct packed {
    cmd_e                cmd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } req_s;

  // Device pins as driven by the host
  typedef struct packed {
    logic                chip_select_n;
    logic                output_enable_n;
    logic                write_enable_n;
    logic [ADDR_W-1:0]   address_bus;
  } pins_s;

endpackage : nv_host_pkg

// ==== hdl/nv_pin_sync.sv ====
`timescale 1ns/1ps
module nv_pin_sync
  import nv_host_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Async pins in, synchronised copy out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Two flops; first stage read only by the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= {W{1'b1}};
      sync_ff <= {W{1'b1}};
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : nv_pin_sync

// ==== testbench/nv_ctrl_sva.sv ====
`timescale 1ns/1ps
module nv_ctrl_sva
  import nv_host_pkg::*;
#(
  parameter int REQ_HOLD = STORE_WAIT_CYC
) (
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              arst_n_i,
  // Handshake
  input wire logic              req_ready_o,
  input wire logic              rsp_valid_o,
  // Device pins
  input wire logic              chip_select_n_o,
  input wire logic              output_enable_n_o,
  input wire logic              write_enable_n_o,
  input wire logic [ADDR_W-1:0] address_bus_o,
  input wire logic              data_bus_oe_o,
  input wire logic              store_busy_n_i,
  input wire logic              store_busy_n_o,
  input wire logic              store_busy_n_oe_o
);
  localparam int HOLD_LAST = REQ_HOLD + 2;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Pin discipline during writes and reads
  property p_wr_addr; !write_enable_n_o && $past(!write_enable_n_o) |-> $stable(address_bus_o);
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write address moved");
  property p_wr_oe; !write_enable_n_o |-> output_enable_n_o; endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("output enable low in write");
  property p_wr_drv; !chip_select_n_o && !write_enable_n_o |-> data_bus_oe_o; endproperty
  a_wr_drv: assert property (p_wr_drv) else $error("write data not driven");
  property p_rd_drv; !output_enable_n_o |-> !data_bus_oe_o; endproperty
  a_rd_drv: assert property (p_rd_drv) else $error("bus contention in read");
  // Busy low for five samples leaves no room for a new request
  property p_busy_block; !store_busy_n_i [*5] |-> !req_ready_o; endproperty
  a_busy_block: assert property (p_busy_block) else $error("request taken while busy");
  property p_ready; req_ready_o |=> !req_ready_o; endproperty
  a_ready: assert property (p_ready) else $error("ready longer than one cycle");
  // Save request pulse has an exact width, then the pin is let go
  property p_hw_hold;
    $rose(store_busy_n_oe_o) |-> ##HOLD_LAST store_busy_n_oe_o ##1 !store_busy_n_oe_o;
  endproperty
  a_hw_hold: assert property (p_hw_hold) else $error("save request width wrong");
  property p_hw_idle; store_busy_n_oe_o |-> !store_busy_n_o && chip_select_n_o; endproperty
  a_hw_idle: assert property (p_hw_idle) else $error("access while pulling busy");
  c_read: cover property (rsp_valid_o);
  c_write: cover property ($fell(write_enable_n_o));
  c_hw: cover property ($rose(store_busy_n_oe_o));
endmodule : nv_ctrl_sva

bind nv_backed_sram_control nv_ctrl_sva #(.REQ_HOLD(REQ_HOLD)) sva_u (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
  .chip_select_n_o(chip_select_n_o), .output_enable_n_o(output_enable_n_o),
  .write_enable_n_o(write_enable_n_o), .address_bus_o(address_bus_o),
  .data_bus_oe_o(data_bus_oe_o), .store_busy_n_i(store_busy_n_i),
  .store_busy_n_o(store_busy_n_o), .store_busy_n_oe_o(store_busy_n_oe_o));

// ==== testbench/nv_sram_model.sv ====
`timescale 1ns/1ps
module nv_sram_model
  import nv_host_pkg::*;
#(
  parameter int SAVE_CYC = 20,
  parameter int REST_CYC = 15,
  parameter int PU_CYC   = 12,
  parameter int WAIT_CYC = 2
) (
  // Clock and power-up
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  // Pins from the host
  input wire logic        cs_n_i,
  input wire logic        oe_n_i,
  input wire logic        we_n_i,
  input wire logic [14:0] addr_i,
  input wire logic [7:0]  dq_i,
  input wire logic        busy_n_i,
  // Supply monitor, high while the supply is below threshold
  input wire logic        supply_low_i,
  // Pins back to the host
  output logic [7:0]      dq_o,
  output logic            dq_oe_o,
  output logic            busy_oe_o,
  output logic            pf_en_o
);
  localparam logic [14:0] SEQ_T [5] = '{SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_A5};
  logic [7:0]  mem [0:32767];
  logic [7:0]  nv  [0:32767];
  logic [14:0] rd_addr;
  logic [2:0]  idx;
  logic        wsl, in_rd, rd_now;
  int          busy_cnt, wait_cnt;
  // Read drive only while selected, enabled and not busy
  assign rd_now    = !cs_n_i && !oe_n_i && we_n_i && busy_n_i;
  assign dq_oe_o   = rd_now;
  assign dq_o      = mem[addr_i];
  assign busy_oe_o = busy_cnt != 0;
  // Array, sequence detector and transfer timing
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idx <= '0; wsl <= 1'b0; pf_en_o <= 1'b1; in_rd <= 1'b0;
      busy_cnt <= PU_CYC; wait_cnt <= 0;
    end else begin
      in_rd <= rd_now;
      if (rd_now) rd_addr <= addr_i;
      if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
      if (!cs_n_i && !we_n_i && busy_n_i) begin
        mem[addr_i] <= dq_i; wsl <= 1'b1; idx <= '0;
      end
      if (in_rd && !rd_now) begin
        if (idx == 3'd5) begin
          idx <= '0;
          case (rd_addr[13:0])
            SEQ_SAVE[13:0]: begin
              busy_cnt <= SAVE_CYC; wsl <= 1'b0; nv <= mem;
            end
            SEQ_RESTORE[13:0]: begin
              busy_cnt <= REST_CYC; wsl <= 1'b0; mem <= nv;
            end
            SEQ_PF_OFF[13:0]:  pf_en_o <= 1'b0;
            SEQ_PF_ON[13:0]:   pf_en_o <= 1'b1;
            default:           ;
          endcase
        end else idx <= (rd_addr[13:0] == SEQ_T[idx][13:0]) ? idx + 3'd1 : 3'd0;
      end
      // Supply drop saves from the reservoir, only if enabled and written
      if (supply_low_i && pf_en_o && wsl && busy_cnt == 0) begin
        busy_cnt <= SAVE_CYC; wsl <= 1'b0; nv <= mem;
      end
      // Outside pull starts a save after the wait, only if written
      if (!busy_n_i && busy_cnt == 0) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt == WAIT_CYC) begin
          wait_cnt <= 0;
          if (wsl) begin busy_cnt <= SAVE_CYC; wsl <= 1'b0; nv <= mem; end
        end
      end else wait_cnt <= 0;
    end
  end
endmodule : nv_sram_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import nv_host_pkg::*;
  logic clk_i, arst_n_i, req_valid_i, req_ready_o, rsp_valid_o, tb_pull, supply_low;
  logic chip_select_n_o, output_enable_n_o, write_enable_n_o, data_bus_oe_o;
  logic store_busy_n_o, store_busy_n_oe_o, mdl_oe, mdl_busy, pf_en;
  logic [14:0] address_bus_o;
  logic [7:0]  rsp_rdata_o, data_bus_o, mdl_dq, last_dq = 8'h00;
  req_s        req_i;
  wire  [7:0]  dq_w;
  logic        busy_w;
  int          fails, cmp_count;
  // Undriven bus drifts each cycle; busy pin has a pull-up
  assign dq_w   = data_bus_oe_o ? data_bus_o : (mdl_oe ? mdl_dq : ~last_dq);
  assign busy_w = !((store_busy_n_oe_o && !store_busy_n_o) || mdl_busy || tb_pull);
  always @(posedge clk_i) last_dq <= dq_w;
  nv_backed_sram_control dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .chip_select_n_o(chip_select_n_o),
    .output_enable_n_o(output_enable_n_o), .write_enable_n_o(write_enable_n_o),
    .address_bus_o(address_bus_o), .data_bus_i(dq_w), .data_bus_o(data_bus_o),
    .data_bus_oe_o(data_bus_oe_o), .store_busy_n_i(busy_w), .store_busy_n_o(store_busy_n_o),
    .store_busy_n_oe_o(store_busy_n_oe_o));
  nv_sram_model mdl_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .cs_n_i(chip_select_n_o),
    .oe_n_i(output_enable_n_o), .we_n_i(write_enable_n_o), .addr_i(address_bus_o),
    .dq_i(dq_w), .busy_n_i(busy_w), .dq_o(mdl_dq), .dq_oe_o(mdl_oe), .busy_oe_o(mdl_busy),
    .pf_en_o(pf_en), .supply_low_i(supply_low));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // Bounded waits end the run when they run dry
  task automatic wait_for(input string what, ref logic sig, input logic lvl);
    int n;
    for (n = 0; n < 600 && sig !== lvl; n++) @(posedge clk_i);
    if (n == 600) begin
      chk(what, 8'h01, 8'h00);
      complete_run();
    end
  endtask : wait_for
  // Hold the request until ready is sampled, then one spare edge
  task automatic issue(input cmd_e c, input logic [14:0] a, input logic [7:0] d);
    req_valid_i <= 1'b1;
    req_i <= '{c, a, d};
    @(posedge clk_i);
    wait_for("ready", req_ready_o, 1'b1);
    req_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask : issue
  task automatic rd(input logic [14:0] a, output logic [7:0] d);
    issue(CMD_READ, a, 8'h00);
    wait_for("response", rsp_valid_o, 1'b1);
    d = rsp_rdata_o;
  endtask : rd
  task automatic sc_rw;
    logic [14:0] at [3] = '{15'h0000, 15'h7FFF, 15'h1234};
    logic [7:0]  vt [3] = '{8'h11, 8'hEE, 8'h5A};
    logic [7:0]  d;
    foreach (at[i]) issue(CMD_WRITE, at[i], vt[i]);
    foreach (at[i]) begin
      rd(at[i], d);
      chk("read data", vt[i], d);
    end
  endtask : sc_rw
  task automatic sc_save_restore;
    logic [7:0] d;
    issue(CMD_WRITE, 15'h0100, 8'hA5);
    issue(CMD_SW_SAVE, 15'h0000, 8'h00);
    wait_for("save busy", busy_w, 1'b0);
    issue(CMD_WRITE, 15'h0100, 8'h3C);
    issue(CMD_SW_RESTORE, 15'h0000, 8'h00);
    rd(15'h0100, d);
    chk("restored data", 8'hA5, d);
  endtask : sc_save_restore
  // Supply low for a few cycles; reports whether a save started
  task automatic drop_supply(output logic seen);
    seen = 1'b0;
    supply_low <= 1'b1;
    repeat (4) begin
      @(posedge clk_i);
      seen |= mdl_busy;
    end
    supply_low <= 1'b0;
  endtask : drop_supply
  task automatic sc_pf;
    logic seen;
    issue(CMD_WRITE, 15'h0300, 8'h77);
    issue(CMD_PF_OFF, 15'h0000, 8'h00);
    wait_for("response", rsp_valid_o, 1'b1);
    chk("save on power fail", 8'h00, {7'h00, pf_en});
    drop_supply(seen);
    chk("save while disabled", 8'h00, {7'h00, seen});
    issue(CMD_PF_ON, 15'h0000, 8'h00);
    wait_for("response", rsp_valid_o, 1'b1);
    chk("save on power fail", 8'h01, {7'h00, pf_en});
    drop_supply(seen);
    chk("supply drop save", 8'h01, {7'h00, seen});
  endtask : sc_pf
  task automatic sc_hw;
    logic seen = 1'b0;
    issue(CMD_WRITE, 15'h0200, 8'h5A);
    issue(CMD_HW_SAVE, 15'h0000, 8'h00);
    wait_for("pin save", mdl_busy, 1'b1);
    issue(CMD_HW_SAVE, 15'h0000, 8'h00);
    repeat (40) begin
      @(posedge clk_i);
      seen |= mdl_busy;
    end
    chk("unwritten save", 8'h00, {7'h00, seen});
  endtask : sc_hw
  // Outside party holds busy low with nothing written
  task automatic sc_ext;
    logic [7:0] d;
    logic seen = 1'b0;
    tb_pull <= 1'b1;
    repeat (12) @(posedge clk_i);
    fork
      rd(15'h0200, d);
      begin
        repeat (30) begin
          @(posedge clk_i);
          seen |= req_ready_o;
        end
        chk("ready while held", 8'h00, {7'h00, seen});
        tb_pull <= 1'b0;
      end
    join
    chk("read after hold", 8'h5A, d);
  endtask : sc_ext
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    arst_n_i = 1'b0; req_valid_i = 1'b0; req_i = '0; tb_pull = 1'b0; supply_low = 1'b0;
    fails = 0; cmp_count = 0;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    sc_rw();
    sc_save_restore();
    sc_pf();
    sc_hw();
    sc_ext();
    complete_run();
  end
endmodule : tb_top
